/* File: verif/ctsm_host.sv */
// Command-port host model that reads status and programs masks
`timescale 1ns/100ps
module ctsm_host (
    input wire logic clk,
    input wire logic [ctsm_pkg::DATA_W-1:0] cmd_rdata,
    input wire logic cmd_rvalid,
    output logic [7:0] cmd_addr,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [ctsm_pkg::DATA_W-1:0] cmd_wdata
);
    import ctsm_pkg::*;

    // Idle bus at time zero
    initial
    begin
        cmd_addr = 8'h00;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = 8'h00;
    end

    // One write strobe; the mask keeps only bits 4..0
    task automatic wr_byte(input logic [7:0] addr, input logic [DATA_W-1:0] data);
        begin
            @(posedge clk);
            #1;
            cmd_addr = addr;
            cmd_wdata = data;
            cmd_wr = 1'b1;
            @(posedge clk);
            #1;
            cmd_wr = 1'b0;
            // Released lines show the inverse so stale values never look valid
            cmd_addr = ~addr;
            cmd_wdata = ~data;
        end
    endtask : wr_byte

    // One read strobe, then a bounded wait for the data-valid pulse
    task automatic rd_byte(input logic [7:0] addr, output logic [DATA_W-1:0] data, output logic ok);
        int n;
        begin
            ok = 1'b0;
            data = 8'h00;
            @(posedge clk);
            #1;
            cmd_addr = addr;
            cmd_rd = 1'b1;
            @(posedge clk);
            #1;
            cmd_rd = 1'b0;
            cmd_addr = ~addr;
            for (n = 0; n < 4 && !ok; n++)
            begin
                if (cmd_rvalid === 1'b1)
                begin
                    data = cmd_rdata;
                    ok = 1'b1;
                end
                else
                begin
                    @(posedge clk);
                    #1;
                end
            end
        end
    endtask : rd_byte
endmodule : ctsm_host

/* File: verif/tb_ctsm_top.sv */
// Self-checking bench for the critical-temperature status and mask block
`timescale 1ns/100ps
module tb_ctsm_top;
    import ctsm_pkg::*;
    typedef struct {int ch; logic [7:0] temp; logic ea; logic ebc;} ctsm_row_t;

    logic clk, rst_n;
    logic [NUM_CH-1:0] conv_done;
    logic [NUM_CH-1:0][TEMP_W-1:0] temp_ch, lim_pri;
    logic [TEMP_W-1:0] lim_sec_rem1, lim_sec_rem2, hyst;
    logic [STAT_W-1:0] mask_b, mask_c, mask_a, exp_a, exp_bc;
    logic [7:0] cmd_addr;
    logic cmd_wr, cmd_rd, cmd_rvalid;
    logic [DATA_W-1:0] cmd_wdata, cmd_rdata;
    logic crit_alarm_out_a_n, crit_alarm_out_b_n, crit_alarm_out_c_n, summary_flag_b, summary_flag_c;
    int failures, check_count;

    // Hysteresis walks around the local and remote 1 limits, equal-to boundaries included
    ctsm_row_t rows [14] = '{'{1, 8'h40, 1'h0, 1'h1}, '{1, 8'h60, 1'h1, 1'h1}, '{1, 8'h5C, 1'h1, 1'h1},
        '{1, 8'h5A, 1'h0, 1'h1}, '{1, 8'h3C, 1'h0, 1'h1}, '{1, 8'h3A, 1'h0, 1'h0}, '{0, 8'h50, 1'h1, 1'h1},
        '{0, 8'h4F, 1'h1, 1'h1}, '{0, 8'h4A, 1'h0, 1'h0}, '{4, 8'hFF, 1'h1, 1'h1}, '{3, 8'h4B, 1'h0, 1'h0},
        '{2, 8'h44, 1'h0, 1'h0}, '{2, 8'h60, 1'h1, 1'h1}, '{3, 8'h50, 1'h1, 1'h1}};

    ctsm_top #(.TEMP_W(TEMP_W)) dut (.clk(clk), .rst_n(rst_n), .conv_done(conv_done), .temp_ch(temp_ch),
        .lim_pri(lim_pri), .lim_sec_rem1(lim_sec_rem1), .lim_sec_rem2(lim_sec_rem2), .hyst(hyst),
        .mask_b(mask_b), .mask_c(mask_c), .cmd_addr(cmd_addr), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .crit_alarm_out_a_n(crit_alarm_out_a_n), .crit_alarm_out_b_n(crit_alarm_out_b_n),
        .crit_alarm_out_c_n(crit_alarm_out_c_n), .summary_flag_b(summary_flag_b), .summary_flag_c(summary_flag_c));

    ctsm_host host (.clk(clk), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_addr(cmd_addr),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata));

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic print_verdict;
        begin
            if (failures == 0 && check_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask : print_verdict

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        begin
            check_count++;
            if (got !== exp)
            begin
                failures++;
                $display("wrong value %s expected %h seen %h", name, exp, got);
            end
        end
    endtask : chk8

    task automatic chk1(input string name, input logic exp, input logic got);
        begin
            check_count++;
            if (got !== exp)
            begin
                failures++;
                $display("wrong value %s expected %b seen %b", name, exp, got);
            end
        end
    endtask : chk1

    // A read that never answers ends the run as a failure
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string name);
        logic [7:0] d;
        logic ok;
        begin
            host.rd_byte(addr, d, ok);
            if (!ok)
            begin
                failures++;
                print_verdict();
            end
            else
                chk8(name, exp, d);
        end
    endtask : rd_chk

    // Pins are active low; summary flags follow the unmasked-agnostic status
    task automatic chk_pins;
        begin
            chk1("alarm a", ~|(exp_a & ~mask_a), crit_alarm_out_a_n);
            chk1("alarm b", ~|(exp_bc & ~mask_b), crit_alarm_out_b_n);
            chk1("alarm c", ~|(exp_bc & ~mask_c), crit_alarm_out_c_n);
            chk1("summary b", |exp_bc, summary_flag_b);
            chk1("summary c", |exp_bc, summary_flag_c);
        end
    endtask : chk_pins

    // One conversion pulse; the reading is scrambled afterwards and must be ignored
    task automatic conv(input int ch, input logic [7:0] temp);
        begin
            @(posedge clk);
            #1;
            temp_ch[ch] = temp;
            conv_done[ch] = 1'b1;
            @(posedge clk);
            #1;
            conv_done = '0;
            temp_ch[ch] = ~temp;
            repeat (3) @(posedge clk);
            #1;
        end
    endtask : conv

    task automatic wr_wait(input logic [7:0] addr, input logic [7:0] data);
        begin
            host.wr_byte(addr, data);
            repeat (2) @(posedge clk);
            #1;
        end
    endtask : wr_wait

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        conv_done = '0;
        temp_ch = '0;
        lim_pri = {8'h50, 8'h50, 8'h60, 8'h60, 8'h50};
        lim_sec_rem1 = 8'h40;
        lim_sec_rem2 = 8'h48; // Differs from remote 1 so a swapped limit shows
        hyst = 8'h05;
        mask_b = 5'h00;
        mask_c = 5'h07;
        mask_a = 5'h19;
        exp_a = 5'h00;
        exp_bc = 5'h00;
        failures = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk_pins();
        rd_chk(CMD_MASK_A, 8'h19, "mask a");
        foreach (rows[i])
        begin
            conv(rows[i].ch, rows[i].temp);
            exp_a[rows[i].ch] = rows[i].ea;
            exp_bc[rows[i].ch] = rows[i].ebc;
            rd_chk(CMD_STAT_A, {3'h0, exp_a}, "status a");
            rd_chk(CMD_STAT_B, {3'h0, exp_bc}, "status b");
            rd_chk(CMD_STAT_C, {3'h0, exp_bc}, "status c");
            chk_pins();
        end
        // Mask everything, then only remote 2, with reserved bits written high
        mask_b = 5'h1C;
        wr_wait(CMD_MASK_A, 8'hFF);
        mask_a = 5'h1F;
        chk_pins();
        rd_chk(CMD_MASK_A, 8'h1F, "mask a all");
        mask_b = 5'h00;
        wr_wait(CMD_MASK_A, 8'hE4);
        mask_a = 5'h04;
        chk_pins();
        rd_chk(CMD_MASK_A, 8'h04, "mask a rem2");
        // Status is read-only and unmapped bytes read zero
        host.wr_byte(CMD_STAT_B, 8'h00);
        rd_chk(CMD_STAT_B, {3'h0, exp_bc}, "status b ro");
        rd_chk(8'h0B, 8'h00, "unmapped");
        // Clear every set bit; all pins must release
        conv(2, 8'h00);
        conv(3, 8'h00);
        conv(4, 8'h00);
        exp_a = 5'h00;
        exp_bc = 5'h00;
        chk_pins();
        rd_chk(CMD_STAT_C, 8'h00, "status c clear");
        // Second reset in mid-run with a bit set
        conv(0, 8'h50);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        exp_a = 5'h00;
        exp_bc = 5'h00;
        mask_a = 5'h19;
        @(negedge clk);
        chk_pins();
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd_chk(CMD_MASK_A, 8'h19, "mask a reset");
        rd_chk(CMD_STAT_B, 8'h00, "status b reset");
        print_verdict();
    end
endmodule : tb_ctsm_top

/* File: verilog/ctsm_hyst.sv */
// One channel's critical comparator with shared hysteresis
`timescale 1ns/100ps
module ctsm_hyst #(
    parameter int TEMP_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic upd,
    input wire logic [TEMP_W-1:0] temp,
    input wire logic [TEMP_W-1:0] limit,
    input wire logic [TEMP_W-1:0] hyst,
    output logic flag
);
    import ctsm_pkg::*;

    logic flag_q;
    logic flag_d;
    logic hot;
    logic cool;

    // Compare on one extra bit so limit minus hysteresis never wraps
    always_comb
    begin
        hot = (temp >= limit);
        cool = (({1'b0, temp} + {1'b0, hyst}) < {1'b0, limit});
        flag_d = flag_q;
        if (upd)
        begin
            if (hot)
                flag_d = 1'b1;
            else if (cool)
                flag_d = 1'b0;
        end
    end

    // Status flag register; only a finished conversion may move it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    assign flag = flag_q;

    sequence s_hot_conv;
        upd && (temp >= limit);
    endsequence

    sequence s_cool_conv;
        upd && (({1'b0, temp} + {1'b0, hyst}) < {1'b0, limit});
    endsequence

    set_on_hot_a: assert property (@(posedge clk) disable iff (!rst_n) s_hot_conv |=> flag)
        else $error("flag not set after reading at or above limit");

    clear_on_cool_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_cool_conv |=> !flag)
        else $error("flag not cleared below limit minus hysteresis");

    hold_between_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!upd || (!(temp >= limit) && !(({1'b0, temp} + {1'b0, hyst}) < {1'b0, limit})))
        |=> $stable(flag))
        else $error("flag moved without a qualifying conversion");

endmodule : ctsm_hyst

/* File: verilog/ctsm_pkg.sv */
// Shared constants for the critical-temperature status and mask block
package ctsm_pkg;

    // Channel count and bit positions within every status and mask register
    localparam int NUM_CH = 5;
    localparam int STAT_W = 5;
    localparam int CH_LOCAL = 0;
    localparam int CH_REM1 = 1;
    localparam int CH_REM2 = 2;
    localparam int CH_REM3 = 3;
    localparam int CH_REM4 = 4;

    // Data widths of the command port and of readings and limits
    localparam int DATA_W = 8;
    localparam int TEMP_W = 8;

    // Command bytes
    localparam logic [7:0] CMD_STAT_A = 8'h08;
    localparam logic [7:0] CMD_STAT_B = 8'h09;
    localparam logic [7:0] CMD_STAT_C = 8'h0A;
    localparam logic [7:0] CMD_MASK_A = 8'h0C;

    // Reset values
    localparam logic [STAT_W-1:0] MASK_A_RST = 5'h19;
    localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

    // Reserved upper bits of every register in this block
    localparam logic [2:0] RSVD_ZERO = 3'h0;

endpackage : ctsm_pkg

/* File: verilog/ctsm_top.sv */
// Critical-temperature status registers, first-output mask and alarm pins
//
// What this block does
// - Second critical status register, command 0x09, bits 4..0 remote4..remote1, local.
// - Third critical status register, command 0x0A, same channel layout.
// - Bits 7 to 5 of these registers always read zero.
// - Status bit sets when reading is at or above the channel critical limit.
// - Bit clears below limit minus common hysteresis, otherwise holds.
// - Second and third status use secondary limits for remotes 1 and 2.
// - Critical output asserts while any unmasked status bit is set.
// - Critical output deasserts once all its status bits are clear.
// - First-output mask register, command 0x0C, read/write, resets to 0x19.
// - Mask bit one blocks the channel from the first output, zero passes it.
// - First-output mask for remotes 1 and 2 gates primary-limit events.
// - First output driven from status register 0x08 using primary limits.
// - Secondary remote 1 and 2 limits come from input ports lim_sec_rem1, lim_sec_rem2.
// - Summary flags show whether second and third status registers have bits set.
`timescale 1ns/100ps
module ctsm_top #(
    parameter int TEMP_W = ctsm_pkg::TEMP_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ctsm_pkg::NUM_CH-1:0] conv_done,
    input wire logic [ctsm_pkg::NUM_CH-1:0][TEMP_W-1:0] temp_ch,
    input wire logic [ctsm_pkg::NUM_CH-1:0][TEMP_W-1:0] lim_pri,
    input wire logic [TEMP_W-1:0] lim_sec_rem1,
    input wire logic [TEMP_W-1:0] lim_sec_rem2,
    input wire logic [TEMP_W-1:0] hyst,
    input wire logic [ctsm_pkg::STAT_W-1:0] mask_b,
    input wire logic [ctsm_pkg::STAT_W-1:0] mask_c,
    input wire logic [7:0] cmd_addr,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [ctsm_pkg::DATA_W-1:0] cmd_wdata,
    output logic [ctsm_pkg::DATA_W-1:0] cmd_rdata,
    output logic cmd_rvalid,
    output logic crit_alarm_out_a_n,
    output logic crit_alarm_out_b_n,
    output logic crit_alarm_out_c_n,
    output logic summary_flag_b,
    output logic summary_flag_c
);
    import ctsm_pkg::*;

    // Per-level status vectors, one bit per channel
    logic [STAT_W-1:0] stat_a;
    logic [STAT_W-1:0] stat_b;
    logic [STAT_W-1:0] stat_c;

    // Register state
    logic [STAT_W-1:0] mask_a_q;
    logic [STAT_W-1:0] mask_a_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    // Pin and summary state
    logic alarm_a_n_q;
    logic alarm_a_n_d;
    logic alarm_b_n_q;
    logic alarm_b_n_d;
    logic alarm_c_n_q;
    logic alarm_c_n_d;
    logic sum_b_q;
    logic sum_b_d;
    logic sum_c_q;
    logic sum_c_d;

    // Named views of the first-output mask fields
    logic local_block;
    logic rem1_block_a;
    logic rem2_block_a;
    logic rem3_block;
    logic rem4_block;

    // Named views of the second and third status fields
    logic local_over_b;
    logic rem1_over_b;
    logic rem2_over_b;
    logic rem3_over_b;
    logic rem4_over_b;
    logic local_over_c;
    logic rem1_over_c;
    logic rem2_over_c;
    logic rem3_over_c;
    logic rem4_over_c;

    // Three comparators per channel; b and c share limits but keep separate
    // flags so a future per-level limit needs no restructuring
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
        logic [TEMP_W-1:0] lim_bc;

        // Remotes 1 and 2 switch to their secondary limits for levels b and c
        if (ch == CH_REM1)
        begin : g_sec1
            assign lim_bc = lim_sec_rem1;
        end
        else if (ch == CH_REM2)
        begin : g_sec2
            assign lim_bc = lim_sec_rem2;
        end
        else
        begin : g_pri
            assign lim_bc = lim_pri[ch];
        end

        // Level a always compares against the primary limit
        ctsm_hyst #(
            .TEMP_W(TEMP_W)
        ) u_hyst_a (
            .clk(clk),
            .rst_n(rst_n),
            .upd(conv_done[ch]),
            .temp(temp_ch[ch]),
            .limit(lim_pri[ch]),
            .hyst(hyst),
            .flag(stat_a[ch])
        );

        ctsm_hyst #(
            .TEMP_W(TEMP_W)
        ) u_hyst_b (
            .clk(clk),
            .rst_n(rst_n),
            .upd(conv_done[ch]),
            .temp(temp_ch[ch]),
            .limit(lim_bc),
            .hyst(hyst),
            .flag(stat_b[ch])
        );

        ctsm_hyst #(
            .TEMP_W(TEMP_W)
        ) u_hyst_c (
            .clk(clk),
            .rst_n(rst_n),
            .upd(conv_done[ch]),
            .temp(temp_ch[ch]),
            .limit(lim_bc),
            .hyst(hyst),
            .flag(stat_c[ch])
        );
    end

    // Field names over the vectors
    assign local_block = mask_a_q[CH_LOCAL];
    assign rem1_block_a = mask_a_q[CH_REM1];
    assign rem2_block_a = mask_a_q[CH_REM2];
    assign rem3_block = mask_a_q[CH_REM3];
    assign rem4_block = mask_a_q[CH_REM4];
    assign local_over_b = stat_b[CH_LOCAL];
    assign rem1_over_b = stat_b[CH_REM1];
    assign rem2_over_b = stat_b[CH_REM2];
    assign rem3_over_b = stat_b[CH_REM3];
    assign rem4_over_b = stat_b[CH_REM4];
    assign local_over_c = stat_c[CH_LOCAL];
    assign rem1_over_c = stat_c[CH_REM1];
    assign rem2_over_c = stat_c[CH_REM2];
    assign rem3_over_c = stat_c[CH_REM3];
    assign rem4_over_c = stat_c[CH_REM4];

    // Command port: mask write, register read with reserved bits zeroed
    always_comb
    begin
        mask_a_d = mask_a_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (cmd_wr && (cmd_addr == CMD_MASK_A))
            mask_a_d = cmd_wdata[STAT_W-1:0];
        if (cmd_rd)
        begin
            rvalid_d = 1'b1;
            case (cmd_addr)
                CMD_STAT_A: rdata_d = {RSVD_ZERO, stat_a};
                CMD_STAT_B: rdata_d = {RSVD_ZERO, rem4_over_b, rem3_over_b, rem2_over_b,
                                       rem1_over_b, local_over_b};
                CMD_STAT_C: rdata_d = {RSVD_ZERO, rem4_over_c, rem3_over_c, rem2_over_c,
                                       rem1_over_c, local_over_c};
                CMD_MASK_A: rdata_d = {RSVD_ZERO, rem4_block, rem3_block, rem2_block_a,
                                       rem1_block_a, local_block};
                default: rdata_d = RDATA_RST; // Unmapped here reads zero
            endcase
        end
    end

    // Command port registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_a_q <= MASK_A_RST;
            rdata_q <= RDATA_RST;
            rvalid_q <= 1'b0;
        end
        else
        begin
            mask_a_q <= mask_a_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Alarm levels; a masked bit still shows in status but never pulls the pin
    always_comb
    begin
        alarm_a_n_d = ~(|(stat_a & ~mask_a_q));
        alarm_b_n_d = ~(|(stat_b & ~mask_b));
        alarm_c_n_d = ~(|(stat_c & ~mask_c));
        sum_b_d = |stat_b;
        sum_c_d = |stat_c;
    end

    // Pins idle high through reset so no false alarm at power-on
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_a_n_q <= 1'b1;
            alarm_b_n_q <= 1'b1;
            alarm_c_n_q <= 1'b1;
            sum_b_q <= 1'b0;
            sum_c_q <= 1'b0;
        end
        else
        begin
            alarm_a_n_q <= alarm_a_n_d;
            alarm_b_n_q <= alarm_b_n_d;
            alarm_c_n_q <= alarm_c_n_d;
            sum_b_q <= sum_b_d;
            sum_c_q <= sum_c_d;
        end
    end

    assign cmd_rdata = rdata_q;
    assign cmd_rvalid = rvalid_q;
    assign crit_alarm_out_a_n = alarm_a_n_q;
    assign crit_alarm_out_b_n = alarm_b_n_q;
    assign crit_alarm_out_c_n = alarm_c_n_q;
    assign summary_flag_b = sum_b_q;
    assign summary_flag_c = sum_c_q;

    // Steps of the alarm path, each used by one check
    sequence s_unmasked_a;
        |(stat_a & ~mask_a_q);
    endsequence

    sequence s_unmasked_b;
        |(stat_b & ~mask_b);
    endsequence

    sequence s_quiet_c;
        stat_c == STAT_RST;
    endsequence

    alarm_a_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_unmasked_a |=> !crit_alarm_out_a_n)
        else $error("first alarm not driven for unmasked status");

    alarm_a_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(|(stat_a & ~mask_a_q)) |=> crit_alarm_out_a_n)
        else $error("first alarm driven by masked or clear status");

    alarm_b_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_unmasked_b |=> !crit_alarm_out_b_n)
        else $error("second alarm not driven for unmasked status");

    alarm_c_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_quiet_c |=> crit_alarm_out_c_n)
        else $error("third alarm stays active with status clear");

    mask_reset_a: assert property (@(posedge clk) $rose(rst_n) |-> mask_a_q == MASK_A_RST)
        else $error("first mask not at reset value after reset");

    mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_wr && cmd_addr == CMD_MASK_A) |=> mask_a_q == $past(cmd_wdata[STAT_W-1:0]))
        else $error("first mask write not stored");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_rvalid |-> cmd_rdata[7:5] == RSVD_ZERO)
        else $error("reserved bits read nonzero");

    read_stat_b_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_rd && cmd_addr == CMD_STAT_B) |=> cmd_rvalid ##0 cmd_rdata == {RSVD_ZERO, $past(stat_b)})
        else $error("second status read returned wrong value");

    read_stat_c_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_rd && cmd_addr == CMD_STAT_C) |=> cmd_rdata == {RSVD_ZERO, $past(stat_c)})
        else $error("third status read returned wrong value");

    summary_b_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 summary_flag_b == ($past(stat_b) != STAT_RST))
        else $error("second summary flag disagrees with status");

    sec_limit_b_a: assert property (@(posedge clk) disable iff (!rst_n)
        (conv_done[CH_REM1] && temp_ch[CH_REM1] >= lim_sec_rem1) |=> stat_b[CH_REM1])
        else $error("remote 1 level b ignores secondary limit");

endmodule : ctsm_top
